// [pwmt_pkg.sv]
// Purpose: Shared constants and types for the eight-channel waveform timer
// Assumes: Single clock, synchronous active-high reset
// Notes:   Channel configuration travels as packed structs
package pwmt_pkg;
	localparam int NCH = 8;
	localparam int NPAIR = 4;
	localparam int CW = 8;
	localparam logic [7:0] RST_PERIOD = 8'hFF;
	localparam logic [7:0] RST_DUTY = 8'h00;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] CNT_ONE = 16'h0001;

	typedef struct packed {
		logic [7:0] period;
		logic [7:0] duty;
	} pwmt_chan_t;

	typedef struct packed {
		logic       enable;
		logic       active_high;
		logic       center;
	} pwmt_mode_t;
endpackage

// [pwmt_timer.sv]
// Purpose: Eight 8-bit waveform channels, pairable into 16-bit channels
// Assumes: Configuration inputs come from logic on the same clock
// Notes:   Period and duty are shadowed and loaded at a period boundary or while disabled; mode bits act at once
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Eight channels, each with its own 8-bit counter, running independently.
// - Each channel has software period and duty values driving its waveform.
// - Duty selectable from constant inactive at zero to constant active at full.
// - Per-channel polarity chooses whether the active portion is high or low.
// - Per-channel left-aligned up-count wrap or center-aligned up-down counting.
// - Adjacent pairs concatenate into one 16-bit channel with 16-bit period and duty.
// - Pair joining is independent per pair, giving every 8/0 through 0/4 mix.
module pwmt_timer
(
	// Clock and reset
	input  wire logic                              clk,
	input  wire logic                              reset,
	// Channel settings
	input  wire pwmt_pkg::pwmt_chan_t [7:0]        chan_cfg,
	input  wire pwmt_pkg::pwmt_mode_t [7:0]        chan_mode,
	input  wire logic [3:0]                        pair_join,
	// Waveform outputs
	output logic [7:0]                             wave_out,
	output logic [7:0]                             period_start
);

	////////////////////////////////////////////////////////////////////////////////
	// Per-pair state: joined pairs use the odd channel's mode bits and the even
	// output; the odd output then idles at its inactive level.
	logic [7:0][15:0] cnt_r, cnt_nxt;
	logic [7:0][15:0] per_r, per_nxt;
	logic [7:0][15:0] duty_r, duty_nxt;
	logic [7:0]       down_r, down_nxt;
	logic [7:0]       wave_nxt;
	logic [7:0]       bound_nxt;
	logic [3:0]       join_r, join_nxt;

	always_comb
	begin
		logic [15:0] per_w;
		logic [15:0] duty_w;
		logic        boundary;
		logic        active;
		logic        jn;
		int          src;
		per_w = pwmt_pkg::CNT_ZERO;
		duty_w = pwmt_pkg::CNT_ZERO;
		boundary = 1'b0;
		active = 1'b0;
		jn = 1'b0;
		src = 0;
		cnt_nxt = cnt_r;
		per_nxt = per_r;
		duty_nxt = duty_r;
		down_nxt = down_r;
		wave_nxt = 8'h00;
		bound_nxt = 8'h00;
		join_nxt = join_r;
		for (int c = 0; c < pwmt_pkg::NCH; c++)
		begin
			jn = join_r[c/2];
			src = jn ? ((c/2)*2 + 1) : c;
			// Joined: odd channel holds high bytes, even channel low bytes
			if (jn)
			begin
				per_w = {chan_cfg[(c/2)*2+1].period, chan_cfg[(c/2)*2].period};
				duty_w = {chan_cfg[(c/2)*2+1].duty, chan_cfg[(c/2)*2].duty};
			end
			else
			begin
				per_w = {8'h00, chan_cfg[c].period};
				duty_w = {8'h00, chan_cfg[c].duty};
			end
			if (!chan_mode[src].enable || (jn && c[0]))
			begin
				cnt_nxt[c] = pwmt_pkg::CNT_ZERO;
				down_nxt[c] = 1'b0;
				per_nxt[c] = per_w;
				duty_nxt[c] = duty_w;
				bound_nxt[c] = 1'b0;
				wave_nxt[c] = ~chan_mode[src].active_high;
			end
			else
			begin
				// Each channel counts alone
				if (chan_mode[src].center)
				begin
					// Up to period then down to zero
					// Zero shadow period is a boundary every cycle, as in up-count mode
					boundary = (down_r[c] && (cnt_r[c] <= pwmt_pkg::CNT_ONE))
						|| (per_r[c] == pwmt_pkg::CNT_ZERO);
					if (boundary)
					begin
						cnt_nxt[c] = pwmt_pkg::CNT_ZERO;
						down_nxt[c] = 1'b0;
					end
					else if (!down_r[c] && cnt_r[c] + pwmt_pkg::CNT_ONE >= per_r[c])
					begin
						cnt_nxt[c] = per_r[c];
						down_nxt[c] = 1'b1;
					end
					else if (down_r[c])
						cnt_nxt[c] = cnt_r[c] - pwmt_pkg::CNT_ONE;
					else
						cnt_nxt[c] = cnt_r[c] + pwmt_pkg::CNT_ONE;
				end
				else
				begin
					// Up-count and wrap
					boundary = cnt_r[c] + pwmt_pkg::CNT_ONE >= per_r[c];
					down_nxt[c] = 1'b0;
					cnt_nxt[c] = boundary ? pwmt_pkg::CNT_ZERO
						: cnt_r[c] + pwmt_pkg::CNT_ONE;
				end
				bound_nxt[c] = boundary;
				// Shadow load only at the boundary avoids runt pulses
				if (boundary)
				begin
					per_nxt[c] = per_w;
					duty_nxt[c] = duty_w;
				end
				// Duty 0 never active; duty >= period always active
				// Full test also covers a live mode switch leaving the count at the period
				active = (cnt_r[c] < duty_r[c])
					|| (duty_r[c] >= per_r[c] && duty_r[c] != pwmt_pkg::CNT_ZERO);
				// Polarity select
				wave_nxt[c] = chan_mode[src].active_high ? active : ~active;
			end
		end
		// Pair mode changes only when both halves would restart together
		for (int p = 0; p < pwmt_pkg::NPAIR; p++)
		begin
			if (!chan_mode[p*2].enable && !chan_mode[p*2+1].enable)
				join_nxt[p] = pair_join[p];
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			cnt_r <= '0;
			per_r <= '0;
			duty_r <= '0;
			down_r <= 8'h00;
			wave_out <= 8'h00;
			period_start <= 8'h00;
			join_r <= 4'h0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			per_r <= per_nxt;
			duty_r <= duty_nxt;
			down_r <= down_nxt;
			wave_out <= wave_nxt;
			period_start <= bound_nxt;
			join_r <= join_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	// Polarity is taken from the cycle that computed the output, as the
	// settings may change at the very edge that registers it.
	property p_zero_duty_inactive;
		@(posedge clk) disable iff (reset)
		(chan_mode[0].enable && !join_r[0] && duty_r[0] == 16'h0000)
		|=> (wave_out[0] == !$past(chan_mode[0].active_high));
	endproperty
	a_zero_duty_inactive: assert property (p_zero_duty_inactive)
		else $error("zero duty not inactive");

	property p_full_duty_active;
		@(posedge clk) disable iff (reset)
		(chan_mode[2].enable && !join_r[1]
		&& duty_r[2] != 16'h0000 && duty_r[2] >= per_r[2] && per_r[2] != 16'h0000)
		|=> (wave_out[2] == $past(chan_mode[2].active_high));
	endproperty
	a_full_duty_active: assert property (p_full_duty_active)
		else $error("full duty not active");

	property p_hold_settings;
		@(posedge clk) disable iff (reset)
		(!bound_nxt[1] && chan_mode[1].enable && !join_r[0])
		|=> $stable(per_r[1]) && $stable(duty_r[1]);
	endproperty
	a_hold_settings: assert property (p_hold_settings)
		else $error("setting changed mid period");

	property p_left_wrap;
		@(posedge clk) disable iff (reset)
		(chan_mode[3].enable && !chan_mode[3].center && !join_r[1])
		|=> !down_r[3];
	endproperty
	a_left_wrap: assert property (p_left_wrap)
		else $error("left-aligned counter went down");

	property p_center_turn;
		@(posedge clk) disable iff (reset)
		(chan_mode[4].enable && chan_mode[4].center && !join_r[2] && down_r[4]
		&& cnt_r[4] > 16'h0001) |=> (cnt_r[4] == $past(cnt_r[4]) - 16'h0001);
	endproperty
	a_center_turn: assert property (p_center_turn)
		else $error("center counter did not count down");

	property p_count_up;
		@(posedge clk) disable iff (reset)
		(chan_mode[5].enable && !chan_mode[5].center && !join_r[2] && !bound_nxt[5])
		|=> (cnt_r[5] == $past(cnt_r[5]) + 16'h0001);
	endproperty
	a_count_up: assert property (p_count_up)
		else $error("counter did not step");

	property p_joined_odd_idle;
		@(posedge clk) disable iff (reset)
		join_r[3]
		|=> (wave_out[7] == !$past(chan_mode[7].active_high)) && (cnt_r[7] == 16'h0000);
	endproperty
	a_joined_odd_idle: assert property (p_joined_odd_idle)
		else $error("joined odd channel not idle");

	property p_join_locked;
		@(posedge clk) disable iff (reset)
		chan_mode[0].enable |=> $stable(join_r[0]);
	endproperty
	a_join_locked: assert property (p_join_locked)
		else $error("join changed while running");

	property p_polarity;
		@(posedge clk) disable iff (reset)
		(chan_mode[6].enable && !join_r[3] && duty_r[6] == 16'h0000
		&& !chan_mode[6].active_high) |=> wave_out[6];
	endproperty
	a_polarity: assert property (p_polarity)
		else $error("inverted idle not high");

	property p_wave_source;
		@(posedge clk) disable iff (reset)
		(chan_mode[1].enable && !join_r[0] && !chan_mode[1].center && chan_mode[1].active_high)
		|=> (wave_out[1] == (($past(cnt_r[1]) < $past(duty_r[1]))
		|| ($past(duty_r[1]) >= $past(per_r[1]) && $past(duty_r[1]) != 16'h0000)));
	endproperty
	a_wave_source: assert property (p_wave_source)
		else $error("wave mismatch");

	c_left_boundary: cover property (@(posedge clk) bound_nxt[0] && !chan_mode[0].center);
	c_center_boundary: cover property (@(posedge clk) bound_nxt[4] && chan_mode[4].center);
	c_joined_run: cover property (@(posedge clk) join_r[1] && chan_mode[3].enable);
	c_toggle: cover property (@(posedge clk) $rose(wave_out[2]));

endmodule

`default_nettype wire

// [pwmt_load_model.sv]
// Purpose: External load timing each channel's periods
// Assumes: Timer outputs registered on clk
// Notes:   Window runs pulse to pulse, so output skew cancels
`timescale 1ns/10ps
`default_nettype none
module pwmt_load_model
(
	// Clock
	input	wire logic	clk,
	// Timer outputs
	input	wire logic [7:0]	wave_in,
	input	wire logic [7:0]	boundary,
	// Last full period per channel
	output	var int	len [8],
	output	var int	hi [8],
	output	var int	seen [8]
);
	int	run_len [8];
	int	run_hi [8];
	initial
	begin
		run_len = '{default: 0};
		run_hi = '{default: 0};
		seen = '{default: 0};
	end
	always @(posedge clk)
		for (int i = 0; i < 8; i++)
		begin
			run_len[i] <= boundary[i] ? 0 : run_len[i] + 1;
			run_hi[i] <= boundary[i] ? 0 : run_hi[i] + (wave_in[i] ? 1 : 0);
			if (boundary[i])
			begin
				len[i] <= run_len[i] + 1;
				hi[i] <= run_hi[i] + (wave_in[i] ? 1 : 0);
				seen[i] <= seen[i] + 1;
			end
		end
endmodule
`default_nettype wire

// [pwm_eight_channel_timer_tb.sv]
// Purpose: Random rounds of settings checked by period
// Assumes: Mode bits may act at once, so early periods skipped
// Notes:   Odd period of a pair kept small to bound run time
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, w) begin num_checks++; if ((g) !== (w)) begin err_count++; \
	$display("wrong value at %0t ch %0d", $time, i); end end
module pwm_eight_channel_timer_tb;
	logic	clk;
	logic	reset;
	pwmt_pkg::pwmt_chan_t [7:0]	chan_cfg;
	pwmt_pkg::pwmt_mode_t [7:0]	chan_mode;
	logic [3:0]	pair_join;
	logic [7:0]	wave_out;
	logic [7:0]	period_start;
	int	len [8];
	int	hi [8];
	int	seen [8];
	int	err_count;
	int	num_checks;
	int	exp_q [$];
	logic [31:0]	lfsr;
	bit	hung;
	pwmt_timer DUT
	(
		.clk	(clk),
		.reset	(reset),
		.chan_cfg	(chan_cfg),
		.chan_mode	(chan_mode),
		.pair_join	(pair_join),
		.wave_out	(wave_out),
		.period_start	(period_start)
	);
	pwmt_load_model u_load
	(
		.clk	(clk),
		.wave_in	(wave_out),
		.boundary	(period_start),
		.len	(len),
		.hi	(hi),
		.seen	(seen)
	);
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic run_round(logic [3:0] pj);
		int	c [8][4];
		int	b [8];
		int	p, d, l, a, j, k, ok;
		logic [7:0]	m;
		@(posedge clk);
		// Joining only changes while the pairs are idle
		if (pj !== pair_join)
		begin
			for (int i = 0; i < 8; i++)
				chan_mode[i].enable <= 1'b0;
			repeat (2) @(posedge clk);
			pair_join <= pj;
			@(posedge clk);
		end
		for (int i = 0; i < 8; i++)
		begin
			lfsr = lfsr_next(lfsr);
			c[i] = '{i[0] && pj[i/2] ? lfsr[13] : lfsr[4:0] + 2,
				lfsr[10:5] & {6{lfsr[12]}} & (i[0] && pj[i/2] ? 1 : 63), lfsr[14], lfsr[15]};
			chan_cfg[i] <= {8'(c[i][0]), 8'(c[i][1])};
			chan_mode[i] <= {1'b1, 1'(c[i][2]), 1'(c[i][3])};
			b[i] = seen[i];
		end
		m = ~{pj[3], 1'b0, pj[2], 1'b0, pj[1], 1'b0, pj[0], 1'b0};
		for (int i = 0; i < 8; i++)
		begin
			j = i | 1;
			p = pj[i/2] ? c[j][0] * 256 + c[i][0] : c[i][0];
			d = pj[i/2] ? c[j][1] * 256 + c[i][1] : c[i][1];
			j = pj[i/2] ? j : i;
			l = c[j][3] ? 2 * p : p;
			a = d == 0 ? 0 : d >= p ? l : c[j][3] ? 2 * d - 1 : d;
			exp_q.push_back(l);
			exp_q.push_back(c[j][2] ? a : l - a);
		end
		for (k = 0; k < 20000; k++)
		begin
			@(posedge clk);
			ok = 1;
			for (int i = 0; i < 8; i++)
				if (m[i] && seen[i] < b[i] + 4)
					ok = 0;
			if (ok)
				break;
		end
		if (!ok)
		begin
			err_count++;
			hung = 1'b1;
			$display("wrong value at %0t round timed out", $time);
			return;
		end
		for (int i = 0; i < 8; i++)
		begin
			l = exp_q.pop_front();
			a = exp_q.pop_front();
			if (m[i])
			begin
				`CHK(len[i], l)
				`CHK(hi[i], a)
			end
			else
				`CHK(wave_out[i], 1'(c[i][2] == 0))
			`CHK(wave_out[i] === 1'bx, 1'b0)
		end
	endtask
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial
	begin
		reset = 1'b1;
		chan_cfg = '0;
		chan_mode = '0;
		pair_join = 4'h0;
		lfsr = 32'h3710;
		err_count = 0;
		num_checks = 0;
		hung = 1'b0;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		// Same join twice runs settings changes live; a hang stops further rounds
		for (int n = 0; n < 9; n++)
			if (!hung)
				run_round(n < 2 ? 4'h0 : n == 8 ? 4'hA : 4'(20'hF7751 >> (4 * (n - 2))));
		print_verdict();
	end
endmodule
`default_nettype wire
